// File: rtl/spp_pkg.sv
// Constants, types and encodings for the secondary PCI port block.
// Assumes one system clock and a synchronous active-high reset.
// Summary of operation
// RULE_01: Park AD and CBE when idle and granted.
// RULE_02: Initiator drives address, then write data.
// RULE_03: Initiator drives command in address phase.
// RULE_04: Initiator drives byte enables every data phase.
// RULE_05: Claim with device select only on decode hit.
// RULE_06: Master abort without device select in five clocks.
// RULE_07: Drive control deasserted one clock, then release.
// RULE_08: Frame marks start; deassert at final phase.
// RULE_09: Initiator ready held until data phase completes.
// RULE_10: Claim Type 0 configuration when select asserted.
// RULE_11: Interrupt on doorbell, queue, page, power events.
// RULE_12: Per-source masks; release when events clear.
package spp_pkg;
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int EV_W = 4;
  localparam int SYNC_W = AD_W + CBE_W + 6;
  localparam logic [SYNC_W-1:0] SYNC_RST = {{(SYNC_W-1){1'b1}}, 1'b0};
  localparam int DEVSEL_LIMIT = 5;
  // Pins reach the counter two clocks late, so the wait is stretched to
  // give a target that claims on the fifth clock its full time.
  localparam int SYNC_LAG = 2;
  localparam logic [3:0] CNT_LIMIT = 4'(DEVSEL_LIMIT + SYNC_LAG);
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [AD_W-1:0] PARK_AD = 32'h0000_0000;
  localparam logic [CBE_W-1:0] PARK_CBE = 4'h0;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [1:0] TYPE0 = 2'h0;
  localparam int EV_DOORBELL = 0;
  localparam int EV_QUEUE = 1;
  localparam int EV_PAGE = 2;
  localparam int EV_POWER = 3;

  typedef struct packed {
    logic [3:0] cmd;
    logic [AD_W-1:0] addr;
    logic [AD_W-1:0] data;
    logic [CBE_W-1:0] be;
  } spp_req_s;

  typedef struct packed {
    logic [3:0] cmd;
    logic [AD_W-1:0] addr;
  } spp_hit_s;

  typedef enum logic [1:0] {
    INI_IDLE = 2'b00,
    INI_ADDR = 2'b01,
    INI_DATA = 2'b10,
    INI_TURN = 2'b11
  } spp_ini_e;

  typedef enum logic [1:0] {
    TGT_IDLE = 2'b00,
    TGT_CLAIM = 2'b01,
    TGT_TURN = 2'b10
  } spp_tgt_e;
endpackage : spp_pkg

// File: rtl/spp_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_sys_in.
`timescale 1ns/1ps
module spp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = srst_in ? RST_VAL : d_in;
    next_q = srst_in ? RST_VAL : stage1;
  end

  always_ff @(posedge clk_sys_in) begin
    stage1 <= next_stage1;
    q_out <= next_q;
  end
endmodule : spp_sync

// File: rtl/spp_port.sv
// Secondary PCI port: initiator, target claim, parking and interrupt.
// Assumes external pull-ups; oe_n low means this module drives the pin.
// Single data phase transactions only; all pins seen through spp_sync.
`timescale 1ns/1ps
module spp_port (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe_n_out,
  input wire logic [3:0] cbe_n_in,
  output logic [3:0] cbe_n_out,
  output logic cbe_oe_n_out,
  input wire logic frame_n_in,
  output logic frame_n_out,
  output logic frame_oe_n_out,
  input wire logic irdy_n_in,
  output logic irdy_n_out,
  output logic irdy_oe_n_out,
  input wire logic devsel_n_in,
  output logic devsel_n_out,
  output logic devsel_oe_n_out,
  input wire logic trdy_n_in,
  input wire logic gnt_n_in,
  input wire logic idsel_in,
  output logic inta_n_out,
  output logic inta_oe_n_out,
  input wire logic req_valid_in,
  input wire spp_pkg::spp_req_s req_in,
  output logic req_ready_out,
  output logic done_out,
  output logic mabort_out,
  output logic [31:0] rdata_out,
  input wire logic [31:0] tgt_base_in,
  input wire logic [31:0] tgt_mask_in,
  output logic tgt_hit_out,
  output spp_pkg::spp_hit_s tgt_info_out,
  input wire logic [3:0] ev_set_in,
  input wire logic [3:0] ev_clear_in,
  input wire logic [3:0] ev_mask_in,
  output logic [3:0] ev_status_out
);
  logic [spp_pkg::SYNC_W-1:0] sync_q;
  logic [31:0] s_ad;
  logic [3:0] s_cbe;
  logic s_frame_n, s_irdy_n, s_devsel_n, s_trdy_n, s_gnt_n, s_idsel;
  logic frame_prev, next_frame_prev;

  spp_sync #(
    .W(spp_pkg::SYNC_W),
    .RST_VAL(spp_pkg::SYNC_RST)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .d_in({ad_in, cbe_n_in, frame_n_in, irdy_n_in, devsel_n_in,
           trdy_n_in, gnt_n_in, idsel_in}),
    .q_out(sync_q)
  );

  assign {s_ad, s_cbe, s_frame_n, s_irdy_n, s_devsel_n, s_trdy_n, s_gnt_n,
          s_idsel} = sync_q;

  function automatic logic is_type0_cfg(input logic [3:0] cmd,
                                        input logic [1:0] low);
    is_type0_cfg = (cmd == spp_pkg::CMD_CFG_RD ||
                    cmd == spp_pkg::CMD_CFG_WR) && low == spp_pkg::TYPE0;
  endfunction : is_type0_cfg

  function automatic logic is_mem(input logic [3:0] cmd);
    is_mem = cmd == spp_pkg::CMD_MEM_RD || cmd == spp_pkg::CMD_MEM_WR;
  endfunction : is_mem

  // Initiator and pin drive state.
  spp_pkg::spp_ini_e ini, next_ini;
  spp_pkg::spp_req_s cur, next_cur;
  logic [3:0] cnt, next_cnt;
  logic next_req_ready, next_done, next_mabort;
  logic [31:0] next_rdata, next_ad;
  logic [3:0] next_cbe;
  logic next_ad_oe_n, next_cbe_oe_n;
  logic next_frame_n, next_frame_oe_n, next_irdy_n, next_irdy_oe_n;
  logic bus_idle, own_grant, tgt_busy;

  assign bus_idle = s_frame_n && s_irdy_n;
  assign own_grant = !s_gnt_n;

  always_comb begin
    next_ini = ini;
    next_cur = cur;
    next_cnt = cnt;
    next_req_ready = 1'b0;
    next_done = 1'b0;
    next_mabort = 1'b0;
    next_rdata = rdata_out;
    next_ad = spp_pkg::PARK_AD;
    next_cbe = spp_pkg::PARK_CBE;
    next_ad_oe_n = 1'b1;
    next_cbe_oe_n = 1'b1;
    next_frame_n = 1'b1;
    next_frame_oe_n = 1'b1;
    next_irdy_n = 1'b1;
    next_irdy_oe_n = 1'b1;
    case (ini)
      spp_pkg::INI_IDLE: begin
        if (bus_idle && own_grant && !tgt_busy) begin
          next_ad_oe_n = 1'b0; // RULE_01
          next_cbe_oe_n = 1'b0; // RULE_01
          if (req_valid_in) begin
            next_req_ready = 1'b1;
            next_cur = req_in;
            next_ini = spp_pkg::INI_ADDR;
            next_cnt = spp_pkg::CNT_ONE;
            next_frame_n = 1'b0; // RULE_08
            next_frame_oe_n = 1'b0;
            next_ad = req_in.addr; // RULE_02
            next_cbe = req_in.cmd; // RULE_03
          end
        end
      end
      spp_pkg::INI_ADDR: begin
        // One data phase, so frame goes high with irdy going low.
        next_ini = spp_pkg::INI_DATA;
        next_cnt = cnt + spp_pkg::CNT_ONE;
        next_frame_oe_n = 1'b0; // RULE_08
        next_irdy_n = 1'b0; // RULE_09
        next_irdy_oe_n = 1'b0;
        next_cbe = cur.be; // RULE_04
        next_cbe_oe_n = 1'b0;
        next_ad = cur.data; // RULE_02
        next_ad_oe_n = !cur.cmd[0]; // RULE_02
      end
      spp_pkg::INI_DATA: begin
        next_frame_oe_n = 1'b1; // RULE_07
        next_irdy_n = 1'b0; // RULE_09
        next_irdy_oe_n = 1'b0;
        next_cbe = cur.be; // RULE_04
        next_cbe_oe_n = 1'b0;
        next_ad = cur.data;
        next_ad_oe_n = !cur.cmd[0];
        if (!s_devsel_n && !s_trdy_n) begin
          next_ini = spp_pkg::INI_TURN;
          next_done = 1'b1;
          next_rdata = s_ad;
          next_irdy_n = 1'b1; // RULE_07
        end else if (s_devsel_n && cnt >= spp_pkg::CNT_LIMIT) begin
          next_ini = spp_pkg::INI_TURN; // RULE_06
          next_done = 1'b1;
          next_mabort = 1'b1; // RULE_06
          next_irdy_n = 1'b1; // RULE_07
        end else if (cnt < spp_pkg::CNT_LIMIT) begin
          next_cnt = cnt + spp_pkg::CNT_ONE;
        end
      end
      spp_pkg::INI_TURN: begin
        next_ini = spp_pkg::INI_IDLE; // RULE_07
        next_cnt = spp_pkg::CNT_ZERO;
      end
      default: next_ini = spp_pkg::INI_IDLE;
    endcase
    if (srst_in) begin
      next_ini = spp_pkg::INI_IDLE;
      next_cnt = spp_pkg::CNT_ZERO;
      next_rdata = spp_pkg::PARK_AD;
      next_ad_oe_n = 1'b1;
      next_cbe_oe_n = 1'b1;
      next_frame_oe_n = 1'b1;
      next_irdy_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    ini <= next_ini;
    cur <= next_cur;
    cnt <= next_cnt;
    req_ready_out <= next_req_ready;
    done_out <= next_done;
    mabort_out <= next_mabort;
    rdata_out <= next_rdata;
    ad_out <= next_ad;
    ad_oe_n_out <= next_ad_oe_n;
    cbe_n_out <= next_cbe;
    cbe_oe_n_out <= next_cbe_oe_n;
    frame_n_out <= next_frame_n;
    frame_oe_n_out <= next_frame_oe_n;
    irdy_n_out <= next_irdy_n;
    irdy_oe_n_out <= next_irdy_oe_n;
  end

  // Target claim; only transactions this port did not start are decoded.
  spp_pkg::spp_tgt_e tgt, next_tgt;
  logic next_devsel_n, next_devsel_oe_n, next_hit;
  spp_pkg::spp_hit_s next_info;
  logic addr_phase, decode_hit;

  assign tgt_busy = tgt != spp_pkg::TGT_IDLE;
  assign addr_phase = frame_prev && !s_frame_n && ini == spp_pkg::INI_IDLE;
  assign decode_hit = (s_idsel && is_type0_cfg(s_cbe, s_ad[1:0])) ||
                      (is_mem(s_cbe) &&
                       (s_ad & tgt_mask_in) == (tgt_base_in & tgt_mask_in));

  always_comb begin
    next_tgt = tgt;
    next_devsel_n = 1'b1;
    next_devsel_oe_n = 1'b1;
    next_hit = 1'b0;
    next_info = tgt_info_out;
    next_frame_prev = s_frame_n;
    case (tgt)
      spp_pkg::TGT_IDLE: begin
        if (addr_phase && decode_hit) begin // RULE_05 RULE_10
          next_tgt = spp_pkg::TGT_CLAIM;
          next_devsel_n = 1'b0; // RULE_05
          next_devsel_oe_n = 1'b0;
          next_hit = 1'b1;
          next_info = '{cmd: s_cbe, addr: s_ad};
        end
      end
      spp_pkg::TGT_CLAIM: begin
        next_devsel_oe_n = 1'b0;
        if (bus_idle) begin
          next_tgt = spp_pkg::TGT_TURN; // RULE_07
        end else begin
          next_devsel_n = 1'b0; // RULE_10
        end
      end
      spp_pkg::TGT_TURN: next_tgt = spp_pkg::TGT_IDLE; // RULE_07
      default: next_tgt = spp_pkg::TGT_IDLE;
    endcase
    if (srst_in) begin
      next_tgt = spp_pkg::TGT_IDLE;
      next_devsel_oe_n = 1'b1;
      next_hit = 1'b0;
      next_info = '0;
      next_frame_prev = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    tgt <= next_tgt;
    devsel_n_out <= next_devsel_n;
    devsel_oe_n_out <= next_devsel_oe_n;
    tgt_hit_out <= next_hit;
    tgt_info_out <= next_info;
    frame_prev <= next_frame_prev;
  end

  // Interrupt events. The queue source is a live level, not sticky,
  // so the line drops as soon as the queue drains.
  logic [3:0] next_ev;
  logic next_inta_oe_n;

  always_comb begin
    next_ev = (ev_status_out & ~ev_clear_in) | ev_set_in; // RULE_11
    next_ev[spp_pkg::EV_QUEUE] = ev_set_in[spp_pkg::EV_QUEUE]; // RULE_12
    next_inta_oe_n = !(|(next_ev & ~ev_mask_in)); // RULE_12
    if (srst_in) begin
      next_ev = '0;
      next_inta_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    ev_status_out <= next_ev;
    inta_oe_n_out <= next_inta_oe_n;
    inta_n_out <= 1'b0;
  end
endmodule : spp_port

// File: verification/spp_port_monitor.sv
// Checker of the port's pin protocol, handshake and interrupt pin.
// Assumes it is bound into spp_port and sees only its ports.
`timescale 1ns/1ps
module spp_port_monitor (
  input logic clk_sys_in,
  input logic srst_in,
  input logic [31:0] ad_out,
  input logic ad_oe_n_out,
  input logic [3:0] cbe_n_out,
  input logic frame_n_out,
  input logic frame_oe_n_out,
  input logic irdy_n_out,
  input logic irdy_oe_n_out,
  input logic devsel_n_in,
  input logic devsel_n_out,
  input logic devsel_oe_n_out,
  input spp_pkg::spp_req_s req_in,
  input logic req_ready_out,
  input logic done_out,
  input logic mabort_out,
  input logic tgt_hit_out,
  input logic [3:0] ev_mask_in,
  input logic [3:0] ev_status_out,
  input logic inta_oe_n_out
);
  wire [3:0] live = ev_status_out & ~ev_mask_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  property p_park;
    !ad_oe_n_out && frame_oe_n_out && irdy_oe_n_out |->
      ad_out == spp_pkg::PARK_AD && cbe_n_out == spp_pkg::PARK_CBE;
  endproperty
  a_park: assert property (p_park) else $error("bus not parked");
  property p_addr;
    req_ready_out |-> !frame_n_out && !frame_oe_n_out &&
      ad_out == $past(req_in.addr) && cbe_n_out == $past(req_in.cmd);
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_data;
    req_ready_out |=> frame_n_out && !irdy_n_out && !irdy_oe_n_out &&
      cbe_n_out == $past(req_in.be, 2);
  endproperty
  a_data: assert property (p_data) else $error("bad data phase");
  property p_irdy;
    !irdy_oe_n_out && !$past(irdy_n_out) && irdy_n_out |-> done_out;
  endproperty
  a_irdy: assert property (p_irdy) else $error("ready dropped");
  property p_turn;
    done_out |-> !irdy_oe_n_out ##1 irdy_oe_n_out && frame_oe_n_out;
  endproperty
  a_turn: assert property (p_turn) else $error("no release");
  property p_abort;
    req_ready_out ##0 devsel_n_in [*5] |-> ##[1:3] done_out && mabort_out;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_claim;
    $fell(devsel_oe_n_out) |-> tgt_hit_out && !devsel_n_out;
  endproperty
  a_claim: assert property (p_claim) else $error("bad claim");
  property p_inta;
    inta_oe_n_out == ((ev_status_out & ~$past(ev_mask_in)) == 4'h0);
  endproperty
  a_inta: assert property (p_inta) else $error("bad interrupt");
endmodule : spp_port_monitor

bind spp_port spp_port_monitor u_mon (.clk_sys_in, .srst_in, .ad_out,
  .ad_oe_n_out, .cbe_n_out, .frame_n_out, .frame_oe_n_out, .irdy_n_out,
  .irdy_oe_n_out, .devsel_n_in, .devsel_n_out, .devsel_oe_n_out, .req_in,
  .req_ready_out, .done_out, .mabort_out, .tgt_hit_out, .ev_mask_in,
  .ev_status_out, .inta_oe_n_out);

// File: verification/spp_target_model.sv
// Target on the far side of the port: claims when enabled, then ends.
// Assumes the bench resolves every pin through a pull-up.
`timescale 1ns/1ps
module spp_target_model (
  input logic clk_sys_in,
  input logic srst_in,
  input logic en_in,
  input logic [1:0] wait_in,
  input logic [31:0] rdata_in,
  input logic frame_n_in,
  input logic irdy_n_in,
  input logic [3:0] cbe_n_in,
  output logic devsel_n_out,
  output logic trdy_n_out,
  output logic ctl_oe_n_out,
  output logic [31:0] ad_out,
  output logic ad_oe_n_out
);
  logic [1:0] st;
  logic [1:0] cnt;
  logic rd;
  // Devsel comes at once; a slow answer only delays trdy.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      {st, devsel_n_out, trdy_n_out, ctl_oe_n_out, ad_oe_n_out} <= 6'h0f;
    end else begin
      case (st)
        2'h0: if (en_in && !frame_n_in) begin
          {devsel_n_out, ctl_oe_n_out, st} <= 4'h1;
          rd <= !cbe_n_in[0];
          cnt <= wait_in;
        end
        2'h1: begin
          cnt <= cnt - 2'h1;
          if (cnt == 2'h0) begin
            {trdy_n_out, ad_oe_n_out, st} <= {1'b0, !rd, 2'h2};
            ad_out <= rdata_in;
          end
        end
        2'h2: if (!irdy_n_in) begin
          {devsel_n_out, trdy_n_out, ad_oe_n_out, st} <= 5'h1f;
        end
        default: begin
          {ctl_oe_n_out, st} <= 3'h4;
        end
      endcase
    end
  end
endmodule : spp_target_model

// File: verification/spp_port_tb.sv
// Self-checking bench for the secondary port with a target model.
// Assumes pull-ups on every shared line and the bound monitor.
`timescale 1ns/1ps
module spp_port_tb;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [31:0] ad_in, ad_out, rdata_out, tgt_base_in, tgt_mask_in;
  logic [31:0] m_ad, t_ad, m_rd;
  logic [3:0] cbe_n_in, cbe_n_out, ev_set_in, ev_clear_in, ev_mask_in;
  logic [3:0] ev_status_out, t_cbe;
  logic ad_oe_n_out, cbe_oe_n_out, frame_n_in, frame_n_out, frame_oe_n_out;
  logic irdy_n_in, irdy_n_out, irdy_oe_n_out, devsel_n_in, devsel_n_out;
  logic devsel_oe_n_out, trdy_n_in, gnt_n_in, idsel_in, inta_n_out;
  logic inta_oe_n_out, req_valid_in, req_ready_out, done_out, mabort_out;
  logic tgt_hit_out, m_dv, m_tr, m_oe, m_adoe, m_en, t_oe, t_fr, t_ir;
  logic [1:0] m_wait;
  spp_pkg::spp_req_s req_in;
  spp_pkg::spp_hit_s tgt_info_out;
  int errors = 0;
  int cmp_count = 0;
  int seed = 847;
  int cyc = 0;
  assign ad_in = !ad_oe_n_out ? ad_out : !m_adoe ? m_ad : !t_oe ? t_ad : '1;
  assign cbe_n_in = !cbe_oe_n_out ? cbe_n_out : !t_oe ? t_cbe : '1;
  assign frame_n_in = !frame_oe_n_out ? frame_n_out : t_oe | t_fr;
  assign irdy_n_in = !irdy_oe_n_out ? irdy_n_out : t_oe | t_ir;
  assign devsel_n_in = !devsel_oe_n_out ? devsel_n_out : m_oe | m_dv;
  assign trdy_n_in = m_oe | m_tr;
  spp_port dut (.*);
  spp_target_model model (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .en_in(m_en), .wait_in(m_wait), .rdata_in(m_rd),
    .frame_n_in(frame_n_in), .irdy_n_in(irdy_n_in), .cbe_n_in(cbe_n_in),
    .devsel_n_out(m_dv), .trdy_n_out(m_tr), .ctl_oe_n_out(m_oe),
    .ad_out(m_ad), .ad_oe_n_out(m_adoe));
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // Caps the run at 5000 clocks; each handshake wait already gives up after 20.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic ini(input logic [3:0] cmd, input logic ok,
                     input logic [1:0] w);
    int n;
    {m_en, m_wait} = {ok, w};
    m_rd = $random(seed);
    req_in = {cmd, $random(seed), $random(seed), m_rd[3:0]};
    req_valid_in = 1'b1;
    for (n = 0; n < 20 && req_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
    req_valid_in = 1'b0;
    for (n = 0; n < 20 && done_out !== 1'b1; n++) @(negedge clk_sys_in);
    chk("done", 1, done_out);
    chk("abort", !ok, mabort_out);
    repeat (3) @(negedge clk_sys_in);
    if (ok && !cmd[0]) chk("rdata", m_rd, rdata_out);
  endtask : ini
  function automatic logic exp_claim(input logic [3:0] cmd,
                                     input logic [31:0] a, input logic s);
    logic cfg;
    logic mem;
    cfg = (cmd == spp_pkg::CMD_CFG_RD || cmd == spp_pkg::CMD_CFG_WR) &&
          a[1:0] == spp_pkg::TYPE0 && s;
    mem = (cmd == spp_pkg::CMD_MEM_RD || cmd == spp_pkg::CMD_MEM_WR) &&
          (a & tgt_mask_in) == (tgt_base_in & tgt_mask_in);
    exp_claim = cfg || mem;
  endfunction : exp_claim
  task automatic tgt(input logic [3:0] cmd, input logic [31:0] a,
                     input logic s);
    logic seen;
    logic e;
    seen = 1'b0;
    e = exp_claim(cmd, a, s);
    {t_oe, t_fr, t_ir, t_ad, t_cbe, idsel_in} = {3'b001, a, cmd, s};
    @(negedge clk_sys_in);
    {t_fr, t_ir, t_cbe, idsel_in} = 7'h40;
    repeat (6) begin
      @(negedge clk_sys_in);
      seen = seen | tgt_hit_out;
    end
    chk("claim", e, seen);
    if (e) chk("hit_addr", a, tgt_info_out.addr);
    if (e) chk("hit_cmd", cmd, tgt_info_out.cmd);
    t_ir = 1'b1;
    @(negedge clk_sys_in);
    t_oe = 1'b1;
    repeat (6) @(negedge clk_sys_in);
  endtask : tgt
  initial begin
    {req_valid_in, gnt_n_in, idsel_in, t_oe, t_fr, t_ir, m_en} = 7'h0e;
    {m_wait, m_rd, req_in, t_ad, t_cbe} = '0;
    {ev_set_in, ev_clear_in, ev_mask_in} = '0;
    tgt_base_in = 32'h8000_0000;
    tgt_mask_in = 32'hff00_0000;
    repeat (5) @(negedge clk_sys_in);
    srst_in = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    chk("park_ad", spp_pkg::PARK_AD, ad_in);
    chk("park_cbe", spp_pkg::PARK_CBE, cbe_n_in);
    chk("inta_pin", 0, inta_n_out);
    for (int k = 0; k < 8; k++) begin
      ini(k[0] ? spp_pkg::CMD_MEM_WR : spp_pkg::CMD_MEM_RD, k < 6,
        k[2:1]);
    end
    gnt_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    tgt(spp_pkg::CMD_MEM_RD, 32'h80ab_cd00, 1'b0);
    tgt(spp_pkg::CMD_MEM_WR, 32'h7f00_0000, 1'b0);
    tgt(spp_pkg::CMD_CFG_RD, 32'h0000_0040, 1'b1);
    tgt(spp_pkg::CMD_CFG_WR, 32'h0000_0040, 1'b0);
    tgt(spp_pkg::CMD_CFG_WR, 32'h0000_0041, 1'b1);
    for (int j = 0; j < 4; j++) begin
      tgt(j[0] ? spp_pkg::CMD_MEM_WR : spp_pkg::CMD_MEM_RD,
        {8'h80 | 8'(j), 24'($random(seed))}, 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      ev_mask_in = i[2] ? 4'hf : 4'h0;
      ev_set_in[i[1:0]] = 1'b1;
      @(negedge clk_sys_in);
      if (i[1:0] != 2'h1) ev_set_in = 4'h0;
      repeat (3) @(negedge clk_sys_in);
      chk("ev_bit", 1, ev_status_out[i[1:0]]);
      chk("inta", i[2], inta_oe_n_out);
      ev_set_in = 4'h0;
      ev_clear_in[i[1:0]] = 1'b1;
      @(negedge clk_sys_in);
      ev_clear_in = 4'h0;
      repeat (3) @(negedge clk_sys_in);
      chk("inta_off", 1, inta_oe_n_out);
    end
    close_out();
  end
endmodule : spp_port_tb
